// >>> faa_annunciator.sv
// Fault and alarm annunciator: indicator, display selection, reset/ack, log overflow
//
// Function
// - Reset request with a fault present attempts to clear faults, no alarm ack.
// - Reset request with no fault but an alarm pending acknowledges alarms.
// - Indicator is always exactly one of off, flashing or steady.
// - No fault: flash while any alarm active or unacknowledged.
// - Any fault: indicator steady and fault name on red background.
// - Steady fault indication only while the bypass setting is off.
// - At most three fault names shown at once.
// - Up and down keys step the shown fault through the active list.
// - Several unacknowledged alarms are shown in rotation.
// - A cleared but unacknowledged alarm keeps the indicator flashing.
// - Alarms during a fault stay hidden until cleared, but are still logged.
// - Acknowledge hides all alarms except one rising in the ack cycle; flashing continues while any alarm persists.
// - Over 256 unacknowledged log entries reports a log overflow.
// - Alarm conditions come and go by themselves, regardless of acknowledgement.
// - Acknowledge only when key, remote or software reset asserts with no fault pending.
// - Reset key may be routed to software, which then issues the reset.
`timescale 1ns/100ps
`include "faa_map.svh"

module faa_annunciator #(
    parameter int NUM_FAULTS = 8,
    parameter int NUM_ALARMS = 8,
    parameter int FLASH_CYC = `FAA_CLK_HZ / 1000 * `FAA_FLASH_MS,
    parameter int ROT_CYC = `FAA_CLK_HZ / 1000 * `FAA_ROT_MS
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Register bus
    input faa_pkg::faa_wbreq_t wbReq,
    output faa_pkg::faa_wbrsp_t wbRsp,
    // Drive conditions and keypad
    input wire logic [NUM_FAULTS-1:0] faultIn,
    input wire logic [NUM_ALARMS-1:0] alarmIn,
    input faa_pkg::faa_keys_t keys,
    // Indicator and display
    output faa_pkg::faa_ind_t indState,
    output logic indLit,
    output logic faultRedBg,
    output faa_pkg::faa_fdisp_t faultDisp,
    output logic alarmShow,
    output logic [7:0] alarmIdx,
    output logic logOverflow,
    output logic irq
);
    import faa_pkg::*;

    localparam int LCW = 10;
    localparam logic [LCW-1:0] LOG_LIMIT = LCW'(`FAA_LOG_LIMIT);
    localparam logic [LCW-1:0] LOG_MAX = {LCW{1'b1}};

    // Next set bit after 'from', or before it when dir is set, wrapping; returns 'from' when none
    function automatic logic [7:0] nextSet(input logic [255:0] v, input logic [7:0] from,
                                           input int n, input logic dir);
        logic [7:0] res;
        logic found;
        int k;
        int j;
        res = from;
        found = 1'b0;
        for (k = 1; k <= 255; k++) begin
            if (k <= n && !found) begin
                j = dir ? (int'(from) + n - k) % n : (int'(from) + k) % n;
                if (v[j]) begin
                    res = 8'(j);
                    found = 1'b1;
                end
            end
        end
        return res;
    endfunction

    // Register state
    logic [2:0] ctrl_r;
    logic [`FAA_IRQ_W-1:0] iStat_r;
    logic [`FAA_IRQ_W-1:0] iMask_r;
    logic wbAck_r;
    logic [31:0] wbDat_r;
    faa_keys_t keysPrev_r;
    logic [NUM_ALARMS-1:0] alarmPrev_r;
    logic [NUM_FAULTS-1:0] faultPrev_r;
    logic [NUM_FAULTS-1:0] faultLatch_r;
    logic [NUM_ALARMS-1:0] unack_r;
    logic [LCW-1:0] logCnt_r;
    logic [31:0] flashCnt_r;
    logic [31:0] rotCnt_r;
    logic flashPhase_r;
    faa_ind_t ind_r;
    faa_ind_t ind_nxt;
    logic indLit_r;
    logic redBg_r;
    logic [7:0] cursor_r;
    faa_fdisp_t fDisp_r;
    logic [7:0] alarmIdx_r;
    logic alarmShow_r;
    logic ovfl_r;
    logic irq_r;

    // Bus decode
    logic busReq;
    logic busWr;
    logic swRst;
    assign busReq = wbReq.cyc && wbReq.stb && !wbAck_r;
    assign busWr = busReq && wbReq.we && wbReq.sel[0];
    assign swRst = busWr && wbReq.adr == `FAA_REG_CTRL && wbReq.dat[`FAA_CTL_SWRST];

    // Request edges; key may be handed to software instead
    logic keyEdge;
    logic reqPulse;
    logic upEdge;
    logic downEdge;
    assign keyEdge = keys.resetKey && !keysPrev_r.resetKey;
    assign reqPulse = (keyEdge && !ctrl_r[`FAA_CTL_ROUTE])
        || (keys.remoteReset && !keysPrev_r.remoteReset) || swRst;
    assign upEdge = keys.upKey && !keysPrev_r.upKey;
    assign downEdge = keys.downKey && !keysPrev_r.downKey;

    // Condition summary
    logic faultAny;
    logic alarmPend;
    logic faultClr;
    logic ackEv;
    logic [NUM_ALARMS-1:0] alarmRise;
    logic [NUM_FAULTS-1:0] faultRise;
    assign faultAny = |faultLatch_r;
    assign alarmPend = |alarmIn || |unack_r;
    assign faultClr = reqPulse && faultAny;
    assign ackEv = reqPulse && !faultAny && alarmPend;
    assign alarmRise = alarmIn & ~alarmPrev_r;
    assign faultRise = faultIn & ~faultPrev_r;

    // Input history for edge detection
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            keysPrev_r <= '0;
            alarmPrev_r <= '0;
            faultPrev_r <= '0;
        end else begin
            keysPrev_r <= keys;
            alarmPrev_r <= alarmIn;
            faultPrev_r <= faultIn;
        end
    end

    // Fault latch; a clear keeps whatever is still present
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            faultLatch_r <= '0;
        end else if (faultClr) begin
            faultLatch_r <= faultIn;
        end else begin
            faultLatch_r <= faultLatch_r | faultIn;
        end
    end

    // Unacknowledged alarms; a new alarm in the ack cycle survives
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            unack_r <= '0;
        end else begin
            unack_r <= (ackEv ? '0 : unack_r) | alarmRise;
        end
    end

    // Unacknowledged entry count, saturating
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            logCnt_r <= '0;
        end else if (|alarmRise || |faultRise) begin
            logCnt_r <= (ackEv ? LCW'(0) : logCnt_r)
                + ((logCnt_r == LOG_MAX) ? LCW'(0) : LCW'(1));
        end else if (ackEv) begin
            logCnt_r <= '0;
        end
    end

    // Overflow flag
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ovfl_r <= 1'b0;
        end else begin
            ovfl_r <= logCnt_r > LOG_LIMIT;
        end
    end

    // Flash and rotation dividers; long counts are parameters
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            flashCnt_r <= '0;
            flashPhase_r <= 1'b0;
            rotCnt_r <= '0;
        end else begin
            flashCnt_r <= (flashCnt_r >= 32'(FLASH_CYC - 1)) ? '0 : flashCnt_r + 32'd1;
            if (flashCnt_r >= 32'(FLASH_CYC - 1)) begin
                flashPhase_r <= !flashPhase_r;
            end
            rotCnt_r <= (rotCnt_r >= 32'(ROT_CYC - 1)) ? '0 : rotCnt_r + 32'd1;
        end
    end

    // Indicator state choice
    always_comb begin
        case (1'b1)
            faultAny && !ctrl_r[`FAA_CTL_BYPASS]: ind_nxt = FAA_IND_STEADY;
            !faultAny && alarmPend: ind_nxt = FAA_IND_FLASH;
            default: ind_nxt = FAA_IND_OFF;
        endcase
    end

    // Indicator registers; one-hot state drives the lamp
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ind_r <= FAA_IND_OFF;
            indLit_r <= 1'b0;
            redBg_r <= 1'b0;
        end else begin
            ind_r <= ind_nxt;
            redBg_r <= faultAny && !ctrl_r[`FAA_CTL_BYPASS];
            case (ind_nxt)
                FAA_IND_STEADY: indLit_r <= 1'b1;
                FAA_IND_FLASH: indLit_r <= flashPhase_r;
                default: indLit_r <= 1'b0;
            endcase
        end
    end

    // Fault list cursor and three display slots
    logic [255:0] fVec;
    logic [7:0] slot1;
    logic [7:0] slot2;
    int fCount;
    always_comb begin
        fVec = '0;
        fVec[NUM_FAULTS-1:0] = faultLatch_r;
        fCount = $countones(faultLatch_r);
        slot1 = nextSet(fVec, cursor_r, NUM_FAULTS, 1'b0);
        slot2 = nextSet(fVec, slot1, NUM_FAULTS, 1'b0);
    end

    // Cursor stays on an active fault; arrows step through the list
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cursor_r <= '0;
            fDisp_r <= '0;
        end else begin
            if (!fVec[cursor_r] || (downEdge && fCount > 1)) begin
                cursor_r <= nextSet(fVec, cursor_r, NUM_FAULTS, 1'b0);
            end else if (upEdge && fCount > 1) begin
                cursor_r <= nextSet(fVec, cursor_r, NUM_FAULTS, 1'b1);
            end
            fDisp_r.idx0 <= cursor_r;
            fDisp_r.idx1 <= slot1;
            fDisp_r.idx2 <= slot2;
            fDisp_r.valid[0] <= redBg_r && fCount >= 1 && fVec[cursor_r];
            fDisp_r.valid[1] <= redBg_r && fCount >= 2;
            fDisp_r.valid[2] <= redBg_r && fCount >= `FAA_DISP_SLOTS;
        end
    end

    // Alarm name rotation over unacknowledged alarms
    logic [255:0] aVec;
    always_comb begin
        aVec = '0;
        aVec[NUM_ALARMS-1:0] = unack_r;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            alarmIdx_r <= '0;
            alarmShow_r <= 1'b0;
        end else begin
            if (!aVec[alarmIdx_r] || rotCnt_r == '0) begin
                alarmIdx_r <= nextSet(aVec, alarmIdx_r, NUM_ALARMS, 1'b0);
            end
            alarmShow_r <= !faultAny && |unack_r && aVec[alarmIdx_r];
        end
    end

    // Control register; software reset bit self-clears
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctrl_r <= `FAA_CTL_RESET;
        end else if (busWr && wbReq.adr == `FAA_REG_CTRL) begin
            ctrl_r <= {1'b0, wbReq.dat[`FAA_CTL_ROUTE], wbReq.dat[`FAA_CTL_BYPASS]};
        end
    end

    // Interrupt status: events set, write one clears, set wins
    logic [`FAA_IRQ_W-1:0] iSet;
    logic [`FAA_IRQ_W-1:0] iClr;
    always_comb begin
        iSet = '0;
        iSet[`FAA_IRQ_FAULT] = |faultRise;
        iSet[`FAA_IRQ_ALARM] = |alarmRise;
        iSet[`FAA_IRQ_OVFL] = (logCnt_r > LOG_LIMIT) && !ovfl_r;
        iSet[`FAA_IRQ_KEY] = keyEdge && ctrl_r[`FAA_CTL_ROUTE];
        iClr = '0;
        if (busWr && wbReq.adr == `FAA_REG_ISTAT) begin
            iClr = wbReq.dat[`FAA_IRQ_W-1:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            iStat_r <= `FAA_IRQ_RESET;
            iMask_r <= `FAA_IRQ_RESET;
            irq_r <= 1'b0;
        end else begin
            iStat_r <= (iStat_r & ~iClr) | iSet;
            if (busWr && wbReq.adr == `FAA_REG_IMASK) begin
                iMask_r <= wbReq.dat[`FAA_IRQ_W-1:0];
            end
            irq_r <= |(iStat_r & iMask_r);
        end
    end

    // Bus answer: one wait state, unmapped reads return zero
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wbAck_r <= 1'b0;
            wbDat_r <= '0;
        end else begin
            wbAck_r <= busReq;
            wbDat_r <= '0;
            if (busReq && !wbReq.we) begin
                case (wbReq.adr)
                    `FAA_REG_CTRL: wbDat_r <= {29'd0, ctrl_r};
                    `FAA_REG_STATE: wbDat_r <= {27'd0, faultAny, ovfl_r, ind_r};
                    `FAA_REG_FAULT: wbDat_r <= 32'(faultLatch_r);
                    `FAA_REG_ALARM: wbDat_r <= 32'(unack_r);
                    `FAA_REG_ISTAT: wbDat_r <= 32'(iStat_r);
                    `FAA_REG_IMASK: wbDat_r <= 32'(iMask_r);
                    `FAA_REG_LOGCNT: wbDat_r <= 32'(logCnt_r);
                    default: wbDat_r <= '0;
                endcase
            end
        end
    end

    // Outputs, all from flip-flops
    assign wbRsp.ack = wbAck_r;
    assign wbRsp.dat = wbDat_r;
    assign indState = ind_r;
    assign indLit = indLit_r;
    assign faultRedBg = redBg_r;
    assign faultDisp = fDisp_r;
    assign alarmShow = alarmShow_r;
    assign alarmIdx = alarmIdx_r;
    assign logOverflow = ovfl_r;
    assign irq = irq_r;

    // Checks
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_clear_not_ack: assert property (faultClr
        |=> unack_r == ($past(unack_r) | $past(alarmRise)))
        else $error("fault clear touched alarm ack");
    a_ack_clears_all: assert property (ackEv && !(|alarmRise) |=> unack_r == '0)
        else $error("ack left alarms pending");
    a_ind_onehot: assert property ($onehot(ind_r))
        else $error("indicator state not one-hot");
    a_flash_alarm: assert property (!faultAny && alarmPend |=> ind_r == FAA_IND_FLASH)
        else $error("alarm without flashing");
    a_steady_fault: assert property (faultAny && !ctrl_r[`FAA_CTL_BYPASS]
        |=> ind_r == FAA_IND_STEADY && redBg_r)
        else $error("fault without steady lamp");
    a_bypass_steady: assert property (ctrl_r[`FAA_CTL_BYPASS] |=> ind_r != FAA_IND_STEADY)
        else $error("steady lamp with bypass on");
    a_slots_three: assert property (fDisp_r.valid[2] |-> fDisp_r.valid[1])
        else $error("fault slot gap");
    a_hidden_alarm: assert property (faultAny |=> !alarmShow_r)
        else $error("alarm shown during fault");
    a_unacked_flash: assert property ((!faultAny && |unack_r && !reqPulse) [*2]
        |-> ind_r == FAA_IND_FLASH)
        else $error("unacked alarm not flashing");
    a_ovfl_flag: assert property (logCnt_r > LOG_LIMIT |=> ovfl_r)
        else $error("overflow not reported");
    a_one_press: assert property (keyEdge |=> !keyEdge)
        else $error("double action on one press");
    a_bus_ack: assert property (busReq |=> wbAck_r ##1 !wbAck_r)
        else $error("bus ack not single cycle");

    c_fault_clear: cover property (faultClr ##1 !faultAny);
    c_ack_alarm: cover property (ackEv ##1 ind_r == FAA_IND_OFF);
    c_two_step: cover property (faultClr ##[1:20] ackEv);
    c_key_route: cover property (iSet[`FAA_IRQ_KEY] ##[1:20] swRst);
endmodule

// >>> faa_map.svh
// Register map, field positions, reset values and timing for the annunciator
`ifndef FAA_MAP_SVH
`define FAA_MAP_SVH
// Byte offsets of the Wishbone registers
`define FAA_REG_CTRL 8'h00
`define FAA_REG_STATE 8'h04
`define FAA_REG_FAULT 8'h08
`define FAA_REG_ALARM 8'h0C
`define FAA_REG_ISTAT 8'h10
`define FAA_REG_IMASK 8'h14
`define FAA_REG_LOGCNT 8'h18
// Control fields
`define FAA_CTL_BYPASS 0
`define FAA_CTL_ROUTE 1
`define FAA_CTL_SWRST 2
`define FAA_CTL_RESET 3'h0
// Interrupt status fields
`define FAA_IRQ_FAULT 0
`define FAA_IRQ_ALARM 1
`define FAA_IRQ_OVFL 2
`define FAA_IRQ_KEY 3
`define FAA_IRQ_W 4
`define FAA_IRQ_RESET 4'h0
// Event-log limit before overflow is reported
`define FAA_LOG_LIMIT 256
// Timing, in milliseconds, the clock rate and the number of display slots
`define FAA_CLK_HZ 20000000
`define FAA_FLASH_MS 250
`define FAA_ROT_MS 2000
`define FAA_DISP_SLOTS 3
`endif

// >>> faa_panel_model.sv
// Operator keypad model: turns one-cycle press requests into held key levels
`timescale 1ns/100ps
module faa_panel_model (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Press requests and how long a key stays down
    input faa_pkg::faa_keys_t pressReq,
    input wire logic [3:0] holdLen,
    // Key lines to the annunciator
    output faa_pkg::faa_keys_t keys
);
    import faa_pkg::*;
    logic [3:0] holdCnt_r;
    faa_keys_t held_r;
    // One press at a time; a long hold stays one press, keys stay released between presses
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            holdCnt_r <= 4'h0;
            held_r <= '0;
        end else if (pressReq != '0) begin
            held_r <= pressReq;
            holdCnt_r <= holdLen;
        end else if (holdCnt_r != 4'h0) begin
            holdCnt_r <= holdCnt_r - 4'h1;
        end else begin
            held_r <= '0;
        end
    end
    assign keys = held_r;
endmodule

// >>> faa_pkg.sv
// Types shared by the fault and alarm annunciator
package faa_pkg;
    // Indicator state, one-hot
    typedef enum logic [2:0] {
        FAA_IND_OFF = 3'b001,
        FAA_IND_FLASH = 3'b010,
        FAA_IND_STEADY = 3'b100
    } faa_ind_t;
    // Wishbone request from the master
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [7:0] adr;
        logic [31:0] dat;
    } faa_wbreq_t;
    // Wishbone answer to the master
    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } faa_wbrsp_t;
    // Keypad and remote request lines
    typedef struct packed {
        logic resetKey;
        logic remoteReset;
        logic upKey;
        logic downKey;
    } faa_keys_t;
    // Fault names on the display: three slots of 8-bit list indices
    typedef struct packed {
        logic [2:0] valid;
        logic [7:0] idx2;
        logic [7:0] idx1;
        logic [7:0] idx0;
    } faa_fdisp_t;
endpackage

// >>> fault_alarm_annunciator_bench.sv
// Self-checking bench for the fault and alarm annunciator
`timescale 1ns/100ps
`include "faa_map.svh"
module fault_alarm_annunciator_bench;
    import faa_pkg::*;
    // One ordinary case: inputs, reset press, expected indicator and alarm area
    typedef struct packed {
        logic [7:0] flt;
        logic [7:0] alm;
        logic prs;
        faa_ind_t ind;
        logic show;
    } faa_row_t;
    localparam faa_keys_t K_RST = 4'b1000;
    localparam faa_keys_t K_REM = 4'b0100;
    localparam faa_keys_t K_UP = 4'b0010;
    localparam faa_keys_t K_DN = 4'b0001;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    faa_wbreq_t wbReq = '0;
    faa_wbrsp_t wbRsp;
    logic [7:0] faultIn = 8'h00;
    logic [7:0] alarmIn = 8'h00;
    faa_keys_t keys;
    faa_keys_t pressReq = '0;
    logic [3:0] holdLen = 4'h6;
    faa_ind_t indState;
    faa_fdisp_t faultDisp;
    faa_fdisp_t savedDisp;
    logic indLit, faultRedBg, alarmShow, logOverflow, irq;
    logic [7:0] alarmIdx;
    logic [7:0] savedIdx;
    logic savedLit;
    logic [31:0] rd;
    int num_errors = 0;
    int comparisons = 0;
    int cycCnt = 0;
    faa_row_t rows [11];
    // Clock
    always #25 sys_clk = ~sys_clk;
    // Design with short flash and rotation periods
    faa_annunciator #(.NUM_FAULTS(8), .NUM_ALARMS(8), .FLASH_CYC(4), .ROT_CYC(8)) dut_u (
        .sys_clk(sys_clk), .rst(rst), .wbReq(wbReq), .wbRsp(wbRsp), .faultIn(faultIn),
        .alarmIn(alarmIn), .keys(keys), .indState(indState), .indLit(indLit),
        .faultRedBg(faultRedBg), .faultDisp(faultDisp), .alarmShow(alarmShow),
        .alarmIdx(alarmIdx), .logOverflow(logOverflow), .irq(irq));
    faa_panel_model panel_u (.sys_clk(sys_clk), .rst(rst), .pressReq(pressReq),
        .holdLen(holdLen), .keys(keys));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // Classic cycle; request held until ack is seen at a rising edge, the run timeout ends a hang
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd);
        wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hF, adr: adr, dat: wd};
        do begin
            @(posedge sys_clk);
        end while (wbRsp.ack !== 1'b1);
        rd = wbRsp.dat;
        wbReq <= '0;
        @(posedge sys_clk);
    endtask
    task automatic press(input faa_keys_t k);
        pressReq <= k;
        @(posedge sys_clk);
        pressReq <= '0;
        wait_cyc(14);
    endtask
    task automatic summarize();
        if (num_errors == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Ceiling well above the roughly 1000 cycles the sequence needs
    always @(posedge sys_clk) begin
        cycCnt++;
        if (cycCnt == 20000) begin
            num_errors++;
            summarize();
        end
    end
    initial begin
        rows[0] = '{8'h00, 8'h00, 1'b0, FAA_IND_OFF, 1'b0};
        rows[1] = '{8'h00, 8'h01, 1'b0, FAA_IND_FLASH, 1'b1};
        rows[2] = '{8'h00, 8'h00, 1'b0, FAA_IND_FLASH, 1'b1};
        rows[3] = '{8'h00, 8'h00, 1'b1, FAA_IND_OFF, 1'b0};
        rows[4] = '{8'h00, 8'h01, 1'b0, FAA_IND_FLASH, 1'b1};
        rows[5] = '{8'h00, 8'h01, 1'b1, FAA_IND_FLASH, 1'b0};
        rows[6] = '{8'h01, 8'h01, 1'b0, FAA_IND_STEADY, 1'b0};
        rows[7] = '{8'h01, 8'h03, 1'b0, FAA_IND_STEADY, 1'b0};
        rows[8] = '{8'h00, 8'h03, 1'b1, FAA_IND_FLASH, 1'b1};
        rows[9] = '{8'h00, 8'h03, 1'b1, FAA_IND_FLASH, 1'b0};
        rows[10] = '{8'h00, 8'h00, 1'b0, FAA_IND_OFF, 1'b0};
        wait_cyc(20);
        rst <= 1'b0;
        @(posedge sys_clk);
        chk(indState, FAA_IND_OFF);
        chk(irq, 1'b0);
        // Register reset values, unmapped 0x1C included
        for (int i = 0; i < 8; i++) begin
            wb(1'b0, 8'(i * 4), 32'h0);
            chk(rd, (i == 1) ? 32'h1 : 32'h0);
        end
        // Ordinary cases; inputs settle before any press so set-wins never blurs
        foreach (rows[i]) begin
            faultIn <= rows[i].flt;
            alarmIn <= rows[i].alm;
            wait_cyc(4);
            if (rows[i].prs) press(K_RST);
            else wait_cyc(14);
            chk(indState, rows[i].ind);
            chk(alarmShow, rows[i].show);
            chk(faultRedBg, rows[i].ind == FAA_IND_STEADY);
            if (rows[i].ind == FAA_IND_STEADY) chk(indLit, 1'b1);
            // Flashing lamp must invert after one flash half period
            if (rows[i].ind == FAA_IND_FLASH) begin
                savedLit = indLit;
                wait_cyc(4);
                chk(indLit, !savedLit);
            end
        end
        // Four faults: three slots, arrow steps the shown entry
        faultIn <= 8'h0F;
        wait_cyc(6);
        chk(faultDisp.valid, 3'b111);
        chk(faultDisp.idx1, 8'h01);
        chk(faultDisp.idx2, 8'h02);
        savedDisp = faultDisp;
        press(K_DN);
        chk(faultDisp !== savedDisp, 1'b1);
        chk(faultDisp.idx0, 8'h01);
        press(K_UP);
        chk(faultDisp.idx0, savedDisp.idx0);
        faultIn <= 8'h00;
        press(K_RST);
        // Bypass on hides the steady indication
        wb(1'b1, `FAA_REG_CTRL, 32'h1);
        faultIn <= 8'h01;
        wait_cyc(6);
        chk(indState, FAA_IND_OFF);
        wb(1'b0, `FAA_REG_STATE, 32'h0);
        chk(rd, 32'h11);
        // Key routed to software: press only raises a masked then unmasked event
        wb(1'b1, `FAA_REG_CTRL, 32'h2);
        faultIn <= 8'h00;
        wb(1'b1, `FAA_REG_ISTAT, 32'hF);
        wait_cyc(4);
        chk(indState, FAA_IND_STEADY);
        press(K_RST);
        chk(indState, FAA_IND_STEADY);
        chk(irq, 1'b0);
        wb(1'b0, `FAA_REG_ISTAT, 32'h0);
        chk(rd, 32'h8);
        wb(1'b1, `FAA_REG_IMASK, 32'h8);
        wait_cyc(2);
        chk(irq, 1'b1);
        wb(1'b1, `FAA_REG_ISTAT, 32'h8);
        wait_cyc(2);
        chk(irq, 1'b0);
        wb(1'b1, `FAA_REG_CTRL, 32'h4);
        wait_cyc(4);
        chk(indState, FAA_IND_OFF);
        // Log overflow at the 256 boundary, cleared by a quick remote ack
        wb(1'b0, `FAA_REG_LOGCNT, 32'h0);
        chk(rd, 32'h2);
        repeat (256 - rd) begin
            alarmIn <= 8'h01;
            @(posedge sys_clk);
            alarmIn <= 8'h00;
            @(posedge sys_clk);
        end
        wait_cyc(3);
        chk(logOverflow, 1'b0);
        alarmIn <= 8'h02;
        wait_cyc(3);
        chk(logOverflow, 1'b1);
        wb(1'b0, `FAA_REG_LOGCNT, 32'h0);
        chk(rd, 32'h101);
        alarmIn <= 8'h00;
        holdLen <= 4'h1;
        press(K_REM);
        chk(logOverflow, 1'b0);
        // Two unacknowledged alarms rotate within one period
        alarmIn <= 8'h03;
        wait_cyc(4);
        savedIdx = alarmIdx;
        for (int n = 0; n < 9 && alarmIdx === savedIdx; n++) @(negedge sys_clk);
        chk(alarmIdx !== savedIdx, 1'b1);
        @(posedge sys_clk);
        press(K_RST);
        chk(alarmShow, 1'b0);
        // Reset in mid-run with alarms present: state returns to idle
        rst <= 1'b1;
        wait_cyc(2);
        rst <= 1'b0;
        alarmIn <= 8'h00;
        @(posedge sys_clk);
        chk(indState, FAA_IND_OFF);
        chk(logOverflow, 1'b0);
        wb(1'b0, `FAA_REG_ALARM, 32'h0);
        chk(rd, 32'h0);
        wait_cyc(4);
        chk(indState, FAA_IND_OFF);
        summarize();
    end
endmodule
